// ### rtl/ligc_irq.sv
// Sticky interrupt status flags with mask and one level interrupt.
// Assumes the bank pulses clear only for flags it has just returned on a read.
`timescale 1ns/1ps
`include "ligc_regs.svh"
module ligc_irq (
    input wire logic pclk,
    input wire logic presetn,
    ligc_irq_if.keeper irq_if
);

    logic [7:0] status_r;
    logic [7:0] status_nxt;

    // Channel 0 flag: a new event wins over a clear in the same cycle
    always_comb begin
        status_nxt = 8'h00;
        status_nxt[`LIGC_CH0_FLAG_BIT] = irq_if.ch0_event
            | (status_r[`LIGC_CH0_FLAG_BIT] & ~irq_if.clear);
    end

    // Flag storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= `LIGC_INT_STAT_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    assign irq_if.status = status_r;
    assign irq_if.irq = |(status_r & irq_if.mask);

endmodule : ligc_irq

// ### rtl/ligc_irq_if.sv
// Carrier between the register bank and its interrupt flag keeper.
// Assumes both ends run on pclk.
`timescale 1ns/1ps
interface ligc_irq_if;
    logic ch0_event;
    logic clear;
    logic [7:0] mask;
    logic [7:0] status;
    logic irq;

    modport bank (output ch0_event, output clear, output mask, input status, input irq);
    modport keeper (input ch0_event, input clear, input mask, output status, output irq);
endinterface : ligc_irq_if

// ### rtl/ligc_pkg.sv
// Types shared by the line interface global configuration bank.
// Assumes the constants header is included by the files that need numbers.
package ligc_pkg;

    // Master clock rates in kHz
    typedef logic [14:0] ligc_khz_t;

    // Decoded clock rate choices
    typedef enum logic [3:0] {
        LIGC_RATE_NONE,
        LIGC_RATE_1544,
        LIGC_RATE_2048,
        LIGC_RATE_3088,
        LIGC_RATE_4096,
        LIGC_RATE_6176,
        LIGC_RATE_8192,
        LIGC_RATE_12352,
        LIGC_RATE_16384
    } ligc_rate_e;

    // Phases of one APB transfer seen by the slave
    typedef enum logic [1:0] {
        LIGC_PH_IDLE,
        LIGC_PH_SETUP,
        LIGC_PH_ACCESS
    } ligc_phase_e;

endpackage : ligc_pkg

// ### rtl/ligc_rate_dec.sv
// Decoder from the clock rate select code to the expected master clock rate.
// Assumes a stable four-bit code; purely combinational.
`timescale 1ns/1ps
module ligc_rate_dec (
    input wire logic [3:0] code,
    output ligc_pkg::ligc_rate_e rate,
    output ligc_pkg::ligc_khz_t khz
);

    // Code to rate table; reserved codes give no rate
    always_comb begin
        case (code)
            4'h0: rate = ligc_pkg::LIGC_RATE_2048;
            4'h1: rate = ligc_pkg::LIGC_RATE_1544;
            4'h8: rate = ligc_pkg::LIGC_RATE_4096;
            4'h9: rate = ligc_pkg::LIGC_RATE_3088;
            4'ha: rate = ligc_pkg::LIGC_RATE_8192;
            4'hb: rate = ligc_pkg::LIGC_RATE_6176;
            4'hc: rate = ligc_pkg::LIGC_RATE_16384;
            4'hd: rate = ligc_pkg::LIGC_RATE_12352;
            4'he: rate = ligc_pkg::LIGC_RATE_2048;
            4'hf: rate = ligc_pkg::LIGC_RATE_1544;
            default: rate = ligc_pkg::LIGC_RATE_NONE;
        endcase
    end

    // Rate in kHz for the decoded choice
    always_comb begin
        case (rate)
            ligc_pkg::LIGC_RATE_1544: khz = 15'h0608;
            ligc_pkg::LIGC_RATE_2048: khz = 15'h0800;
            ligc_pkg::LIGC_RATE_3088: khz = 15'h0c10;
            ligc_pkg::LIGC_RATE_4096: khz = 15'h1000;
            ligc_pkg::LIGC_RATE_6176: khz = 15'h1820;
            ligc_pkg::LIGC_RATE_8192: khz = 15'h2000;
            ligc_pkg::LIGC_RATE_12352: khz = 15'h3040;
            ligc_pkg::LIGC_RATE_16384: khz = 15'h4000;
            default: khz = 15'h0000;
        endcase
    end

endmodule : ligc_rate_dec

// ### rtl/ligc_regs.svh
// Register indices, field positions, reset values and timing for the
// line interface global configuration bank.
// Assumes a 32-bit APB whose byte address is four times the register index.
`ifndef LIGC_REGS_SVH
`define LIGC_REGS_SVH

// Register indices; byte address is index times four
`define LIGC_IDX_GCR2 16'h0fe2
`define LIGC_IDX_GCR3 16'h0fe4
`define LIGC_IDX_RATE_CTRL 16'h0fe8
`define LIGC_IDX_INT_STAT 16'h0fea
`define LIGC_IDX_INT_MASK 16'h0fec
`define LIGC_IDX_RATE_STAT 16'h0fee
`define LIGC_BYTE_ADDR(idx) ({(idx), 2'b00})

// Field positions
`define LIGC_RATE_SEL_MSB 3
`define LIGC_RATE_SEL_LSB 0
`define LIGC_CH0_FLAG_BIT 0
`define LIGC_RATE_VALID_BIT 31

// Reset values
`define LIGC_GCR2_RST 8'h00
`define LIGC_GCR3_RST 8'h00
`define LIGC_RATE_CTRL_RST 8'h01
`define LIGC_INT_STAT_RST 8'h00
`define LIGC_INT_MASK_RST 8'h00

// Timing: registers answer in the access phase without wait states
`define LIGC_WAIT_CYCLES 0

`endif

// ### rtl/ligc_top.sv
// Line interface global configuration bank with its APB slave.
// Assumes one 100 MHz pclk, an APB master on the same clock and a
// channel 0 interrupt event pulse from logic on that clock.
//
// Functional notes
// - Clock select code 0000 means 2.048 MHz, 0001 means 1.544 MHz, 1100 means 16.384 MHz.
// - Codes 1001, 1011, 1101, 1110, 1111 mean 3.088, 6.176, 12.352, 2.048, 1.544 MHz.
// - The clock select field resets to 0001, a 1.544 MHz master clock.
// - The channel 0 flag reads 1 when a channel 0 interrupt came since the last read.
// - Reading the interrupt status register clears the flag until a new interrupt.
// - Control register two bits 6 to 0 are unused and reset to 0; bit 7 is written 0.
// - The other interrupt status bits are reserved, read 0 and do nothing.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "ligc_regs.svh"
module ligc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ch0_event,
    output logic [3:0] input_clock_rate_select,
    output logic [14:0] mclk_rate_khz,
    output logic mclk_rate_valid,
    output logic irq
);

    // Byte addresses of the registers
    localparam logic [15:0] ADDR_GCR2 = `LIGC_BYTE_ADDR(14'(`LIGC_IDX_GCR2));
    localparam logic [15:0] ADDR_GCR3 = `LIGC_BYTE_ADDR(14'(`LIGC_IDX_GCR3));
    localparam logic [15:0] ADDR_RCTL = `LIGC_BYTE_ADDR(14'(`LIGC_IDX_RATE_CTRL));
    localparam logic [15:0] ADDR_ISTAT = `LIGC_BYTE_ADDR(14'(`LIGC_IDX_INT_STAT));
    localparam logic [15:0] ADDR_IMASK = `LIGC_BYTE_ADDR(14'(`LIGC_IDX_INT_MASK));
    localparam logic [15:0] ADDR_RSTAT = `LIGC_BYTE_ADDR(14'(`LIGC_IDX_RATE_STAT));

    logic [7:0] gcr2_r;
    logic [7:0] gcr3_r;
    logic [7:0] rate_ctrl_r;
    logic [7:0] int_mask_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic stat_read_r;
    logic [14:0] rate_khz_r;
    logic rate_valid_r;
    ligc_pkg::ligc_phase_e phase_r;
    ligc_pkg::ligc_phase_e phase_nxt;
    ligc_pkg::ligc_rate_e rate_dec;
    ligc_pkg::ligc_khz_t khz_dec;
    logic setup_cyc;
    logic access_cyc;
    logic wr_stb;
    logic mapped;
    logic byte0_wr;
    logic access_ok;

    ligc_irq_if irq_link ();

    // Transfer phase decode
    assign setup_cyc = psel & ~penable;
    assign access_cyc = psel & penable;
    assign byte0_wr = pstrb[0];

    // Address decode, valid in both phases
    always_comb begin
        case (paddr)
            ADDR_GCR2: mapped = 1'b1;
            ADDR_GCR3: mapped = 1'b1;
            ADDR_RCTL: mapped = 1'b1;
            ADDR_ISTAT: mapped = 1'b1;
            ADDR_IMASK: mapped = 1'b1;
            ADDR_RSTAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Access edge counts only right after a setup cycle; a stray penable is ignored
    assign access_ok = access_cyc & (phase_r == ligc_pkg::LIGC_PH_SETUP);

    // Writes take effect at the access edge, mapped and lane 0 enabled
    assign wr_stb = access_ok & pwrite & mapped & byte0_wr;

    // Phase tracker
    always_comb begin
        case (phase_r)
            ligc_pkg::LIGC_PH_IDLE: phase_nxt = setup_cyc ? ligc_pkg::LIGC_PH_SETUP
                : ligc_pkg::LIGC_PH_IDLE;
            ligc_pkg::LIGC_PH_SETUP: phase_nxt = ligc_pkg::LIGC_PH_ACCESS;
            ligc_pkg::LIGC_PH_ACCESS: phase_nxt = setup_cyc ? ligc_pkg::LIGC_PH_SETUP
                : ligc_pkg::LIGC_PH_IDLE;
            default: phase_nxt = ligc_pkg::LIGC_PH_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_r <= ligc_pkg::LIGC_PH_IDLE;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // Control register two: stored as written, bit 7 kept by software at 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gcr2_r <= `LIGC_GCR2_RST;
        end else if (wr_stb && paddr == ADDR_GCR2) begin
            gcr2_r <= pwdata[7:0];
        end
    end

    // Control register three: unused storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gcr3_r <= `LIGC_GCR3_RST;
        end else if (wr_stb && paddr == ADDR_GCR3) begin
            gcr3_r <= pwdata[7:0];
        end
    end

    // Clock rate control: select field in the low nibble
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_ctrl_r <= `LIGC_RATE_CTRL_RST;
        end else if (wr_stb && paddr == ADDR_RCTL) begin
            rate_ctrl_r <= pwdata[7:0];
        end
    end

    // Interrupt mask, same layout as the status register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask_r <= `LIGC_INT_MASK_RST;
        end else if (wr_stb && paddr == ADDR_IMASK) begin
            int_mask_r <= pwdata[7:0];
        end
    end

    assign input_clock_rate_select = rate_ctrl_r[`LIGC_RATE_SEL_MSB:`LIGC_RATE_SEL_LSB];

    // Rate decode of the select field
    ligc_rate_dec u_rate_dec (
        .code(rate_ctrl_r[`LIGC_RATE_SEL_MSB:`LIGC_RATE_SEL_LSB]),
        .rate(rate_dec),
        .khz(khz_dec)
    );

    // Registered rate for the clock logic; no rate on a reserved code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_khz_r <= 15'h0000;
            rate_valid_r <= 1'b0;
        end else begin
            rate_khz_r <= khz_dec;
            rate_valid_r <= (rate_dec != ligc_pkg::LIGC_RATE_NONE);
        end
    end

    assign mclk_rate_khz = rate_khz_r;
    assign mclk_rate_valid = rate_valid_r;

    // Read data, captured in the setup cycle
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        case (paddr)
            ADDR_GCR2: prdata_nxt[7:0] = gcr2_r;
            ADDR_GCR3: prdata_nxt[7:0] = gcr3_r;
            ADDR_RCTL: prdata_nxt[7:0] = rate_ctrl_r;
            ADDR_ISTAT: prdata_nxt[7:0] = irq_link.status;
            ADDR_IMASK: prdata_nxt[7:0] = int_mask_r;
            ADDR_RSTAT: begin
                prdata_nxt[14:0] = rate_khz_r;
                prdata_nxt[`LIGC_RATE_VALID_BIT] = rate_valid_r;
            end
            default: prdata_nxt = 32'h0000_0000;
        endcase
    end

    // Error answer for unmapped addresses
    assign pslverr_nxt = ~mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_cyc) begin
            prdata_r <= pwrite ? 32'h0000_0000 : prdata_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    // Remembers a status read whose flag was returned set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_read_r <= 1'b0;
        end else if (setup_cyc) begin
            stat_read_r <= ~pwrite && paddr == ADDR_ISTAT
                && irq_link.status[`LIGC_CH0_FLAG_BIT];
        end
    end

    // Answer in the access phase, no wait states
    assign pready = 1'b1;
    assign prdata = prdata_r;
    assign pslverr = pslverr_r & access_cyc;

    // Flag keeper: clear only what the read returned, event wins
    assign irq_link.ch0_event = ch0_event;
    assign irq_link.clear = access_ok & ~pwrite & stat_read_r;
    assign irq_link.mask = int_mask_r;

    ligc_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .irq_if(irq_link)
    );

    assign irq = irq_link.irq;

endmodule : ligc_top

// ### sim/ligc_top_asserts.sv
// Port-level checks for the line interface global configuration bank.
// Assumes it is bound to ligc_top and shares its pclk and presetn.
`timescale 1ns/1ps
module ligc_top_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ch0_event,
    input wire logic [3:0] input_clock_rate_select,
    input wire logic [14:0] mclk_rate_khz,
    input wire logic mclk_rate_valid,
    input wire logic irq
);
    // Rate in kHz for each select code, zero where the code is reserved
    localparam logic [14:0] KHZ [16] = '{15'h0800, 15'h0608, 15'h0000, 15'h0000,
        15'h0000, 15'h0000, 15'h0000, 15'h0000, 15'h1000, 15'h0c10, 15'h2000,
        15'h1820, 15'h4000, 15'h3040, 15'h0800, 15'h0608};
    logic mask_r;
    logic acc;
    logic st_rd;
    assign acc = psel && penable && pready;
    assign st_rd = psel && !pwrite && paddr == 16'h3fa8;
    // Mirror of the channel 0 mask bit, taken from completed writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= 1'b0;
        end else if (acc && pwrite && pstrb[0] && paddr == 16'h3fb0) begin
            mask_r <= pwdata[0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rate_decode: assert property (
        presetn |=> mclk_rate_khz == KHZ[$past(input_clock_rate_select)]) else $error("rate mismatch");
    a_rate_valid: assert property (
        presetn |=> mclk_rate_valid == (KHZ[$past(input_clock_rate_select)] != 15'h0))
        else $error("valid mismatch");
    a_select_reset: assert property (
        $rose(presetn) |-> input_clock_rate_select == 4'h1) else $error("bad select reset");
    a_select_write: assert property (
        acc && pwrite && pstrb[0] && paddr == 16'h3fa0 |=>
        input_clock_rate_select == $past(pwdata[3:0])) else $error("select not written");
    a_event_irq: assert property (
        ch0_event && mask_r |=> irq) else $error("event lost");
    a_irq_cause: assert property (
        $rose(irq) |-> $past(ch0_event) || $past(pwrite) && $past(penable))
        else $error("irq without cause");
    a_read_clears: assert property (
        acc && st_rd && prdata[0] && !ch0_event && !$past(ch0_event) |=> !irq)
        else $error("flag not cleared");
    a_read_flag: assert property (
        st_rd && !penable && irq |=> prdata[0]) else $error("flag not read");
    a_status_resv: assert property (
        acc && st_rd |-> prdata[31:1] == 31'h0) else $error("reserved status bits set");
    c_event: cover property (ch0_event && mask_r);
    c_clear: cover property (acc && st_rd && prdata[0]);
    c_rate: cover property (acc && pwrite && paddr == 16'h3fa0);
endmodule : ligc_top_asserts

bind ligc_top ligc_top_asserts u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch0_event(ch0_event),
    .input_clock_rate_select(input_clock_rate_select), .mclk_rate_khz(mclk_rate_khz),
    .mclk_rate_valid(mclk_rate_valid), .irq(irq)
);

// ### sim/tb.sv
// Self-checking bench for the line interface global configuration bank.
// Assumes zero wait APB answers and one-cycle channel 0 event pulses.
`timescale 1ns/1ps
module tb;
    logic pclk, presetn, psel, penable, pwrite, ch0_event;
    logic pready, pslverr, mclk_rate_valid, irq;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb, input_clock_rate_select;
    logic [14:0] mclk_rate_khz;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    localparam logic [14:0] KHZ [16] = '{15'h0800, 15'h0608, 15'h0000, 15'h0000,
        15'h0000, 15'h0000, 15'h0000, 15'h0000, 15'h1000, 15'h0c10, 15'h2000,
        15'h1820, 15'h4000, 15'h3040, 15'h0800, 15'h0608};

    ligc_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ch0_event(ch0_event),
        .input_clock_rate_select(input_clock_rate_select), .mclk_rate_khz(mclk_rate_khz),
        .mclk_rate_valid(mclk_rate_valid), .irq(irq)
    );

    // Clock at 100 MHz
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer; data and error are taken at the completing edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, s, r, e);
        chk({31'h0, e}, {31'h0, a == 16'h3fc0});
    endtask : wr

    task automatic rdc(input logic [15:0] a, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, 4'h0, r, e);
        chk(r, x);
        chk({31'h0, e}, {31'h0, a == 16'h3fc0});
    endtask : rdc

    task automatic pulse;
        @(posedge pclk);
        ch0_event <= 1'b1;
        @(posedge pclk);
        ch0_event <= 1'b0;
        #1;
    endtask : pulse

    task automatic t_reset;
        chk({28'h0, input_clock_rate_select}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        rdc(16'h3f88, 32'h0);
        rdc(16'h3f90, 32'h0);
        rdc(16'h3fa0, 32'h1);
        rdc(16'h3fa8, 32'h0);
        rdc(16'h3fb0, 32'h0);
        rdc(16'h3fb8, 32'h80000608);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_rate;
        for (int c = 0; c < 16; c++) begin
            if (c >= 2 && c <= 7) continue;
            wr(16'h3fa0, {28'h0, c[3:0]}, 4'hf);
            @(posedge pclk);
            #1;
            chk({28'h0, input_clock_rate_select}, {28'h0, c[3:0]});
            chk({17'h0, mclk_rate_khz}, {17'h0, KHZ[c]});
            chk({31'h0, mclk_rate_valid}, {31'h0, KHZ[c] != 15'h0});
            rdc(16'h3fb8, {KHZ[c] != 15'h0, 16'h0, KHZ[c]});
        end
        wr(16'h3fa0, 32'hf1, 4'hf);
        rdc(16'h3fa0, 32'hf1);
        $display("t_rate done");
    endtask : t_rate

    task automatic t_regs;
        wr(16'h3f88, 32'h7f, 4'hf);
        rdc(16'h3f88, 32'h7f);
        wr(16'h3f90, 32'ha5, 4'hf);
        wr(16'h3f90, 32'h5a, 4'h0);
        rdc(16'h3f90, 32'ha5);
        wr(16'h3fc0, 32'h1, 4'hf);
        rdc(16'h3fc0, 32'h0);
        wr(16'h3fa8, 32'hff, 4'hf);
        rdc(16'h3fa8, 32'h0);
        $display("t_regs done");
    endtask : t_regs

    task automatic t_irq;
        wr(16'h3fb0, 32'h1, 4'hf);
        pulse();
        chk({31'h0, irq}, 32'h1);
        rdc(16'h3fa8, 32'h1);
        #1;
        chk({31'h0, irq}, 32'h0);
        rdc(16'h3fa8, 32'h0);
        wr(16'h3fb0, 32'h0, 4'hf);
        pulse();
        chk({31'h0, irq}, 32'h0);
        rdc(16'h3fa8, 32'h1);
        fork
            rdc(16'h3fa8, 32'h0);
            begin
                repeat (2) @(posedge pclk);
                ch0_event <= 1'b1;
                @(posedge pclk);
                ch0_event <= 1'b0;
            end
        join
        rdc(16'h3fa8, 32'h1);
        $display("t_irq done");
    endtask : t_irq

    // Cut a hang short after a generous cycle budget
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_count++;
            close_out();
        end
    end

    // Reset for 20 cycles, then the scenarios in turn
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        ch0_event = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_rate();
        t_regs();
        t_irq();
        close_out();
    end
endmodule : tb
